// >>> inc/sqdst_map.svh
// register offsets, field positions, reset values and codes of the squib loop status bank
`ifndef SQDST_MAP_SVH
`define SQDST_MAP_SVH
`define SQDST_STATUS_OFF 8'h00
`define SQDST_IRQ_STAT_OFF 8'h04
`define SQDST_IRQ_MASK_OFF 8'h08
`define SQDST_THRESH_OFF 8'h0c
`define SQDST_LEAK_CH_LSB 0
`define SQDST_LEAK_PIN_BIT 4
`define SQDST_BATT_BIT 5
`define SQDST_GND_BIT 6
`define SQDST_LOOP_BIT 7
`define SQDST_CHECK_LSB 8
`define SQDST_RES_CH_LSB 12
`define SQDST_UNDER_BIT 16
`define SQDST_OVER_BIT 17
`define SQDST_RSVD_BIT 18
`define SQDST_FET_BIT 19
`define SQDST_THR_LOW_LSB 0
`define SQDST_THR_HIGH_LSB 8
`define SQDST_THRESH_RST 16'hff00
`define SQDST_IRQ_RST 4'h0
`define SQDST_EV_RES 0
`define SQDST_EV_LEAK 1
`define SQDST_EV_LOOP 2
`define SQDST_EV_SHORT 3
`define SQDST_CHK_NONE 4'h0
`define SQDST_CHK_REGULATOR_CURRENT_MONITOR 4'h1
`define SQDST_CHK_LEAK 4'h2
`define SQDST_CHK_LOOP 4'h3
`define SQDST_CHK_RANGE 4'h5
`define SQDST_CHK_MEAS 4'h6
`define SQDST_CHK_FET 4'h7
`define SQDST_CH_NONE 4'h4
`define SQDST_RESP_OKAY 2'h0
`define SQDST_RESP_SLVERR 2'h2
`endif

// >>> inc/sqdst_pkg.sv
// shared types of the squib loop status bank
package sqdst_pkg;
    typedef logic [3:0] sqdst_code_t;
    typedef logic [31:0] sqdst_word_t;
    typedef logic [3:0] sqdst_irq_t;
endpackage : sqdst_pkg

// >>> rtl/sqdst_status.sv
// squib loop diagnostic status bank with axi4-lite slave and interrupt
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sqdst_map.svh"

module sqdst_status (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic safety_machine_reset,
    input wire logic diag_state,
    input wire logic hs_fet_on,
    input wire logic ls_fet_on,
    input wire logic fsm_update,
    input wire logic fsm_fet_active,
    input wire logic fsm_over_high,
    input wire logic fsm_under_low,
    input wire logic [3:0] fsm_res_channel,
    input wire logic [3:0] fsm_check_code,
    input wire logic fsm_loop_short,
    input wire logic fsm_ground_short,
    input wire logic fsm_battery_short,
    input wire logic fsm_leak_pin_side,
    input wire logic [3:0] fsm_leak_channel,
    input wire logic res_test_done,
    input wire logic [7:0] res_measured,
    input wire logic res_channel_load,
    input wire logic [3:0] res_channel_cfg,
    input wire logic leak_done,
    input wire logic leak_ground,
    input wire logic leak_battery,
    input wire logic leak_pin_side,
    input wire logic [3:0] leak_channel,
    output logic irq
);

    function automatic sqdst_pkg::sqdst_code_t sqdst_check_clean(input logic [3:0] code);
        case (code)
            `SQDST_CHK_REGULATOR_CURRENT_MONITOR, `SQDST_CHK_LEAK, `SQDST_CHK_LOOP,
            `SQDST_CHK_RANGE, `SQDST_CHK_MEAS, `SQDST_CHK_FET: sqdst_check_clean = code;
            default: sqdst_check_clean = `SQDST_CHK_NONE;
        endcase
    endfunction : sqdst_check_clean

    // status fields
    logic fet_active_flag_reg, fet_active_flag_next;
    logic resist_over_high_reg, resist_over_high_next;
    logic resist_under_low_reg, resist_under_low_next;
    logic [3:0] resistance_channel_reg, resistance_channel_next;
    sqdst_pkg::sqdst_code_t active_check_code_reg, active_check_code_next;
    logic loop_to_loop_short_reg, loop_to_loop_short_next;
    logic ground_short_flag_reg, ground_short_flag_next;
    logic battery_short_flag_reg, battery_short_flag_next;
    logic leak_pin_side_reg, leak_pin_side_next;
    logic [3:0] leak_channel_reg, leak_channel_next;
    logic [7:0] thr_high_reg, thr_high_next;
    logic [7:0] thr_low_reg, thr_low_next;
    sqdst_pkg::sqdst_irq_t irq_stat_reg, irq_stat_next;
    sqdst_pkg::sqdst_irq_t irq_mask_reg, irq_mask_next;
    logic irq_reg, irq_next;
    sqdst_pkg::sqdst_irq_t ev;
    sqdst_pkg::sqdst_word_t status_word;

    // bus slave state
    logic aw_held_reg, aw_held_next;
    logic [7:0] aw_addr_reg, aw_addr_next;
    logic w_held_reg, w_held_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic wr_fire;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    always_comb begin
        status_word = '0;
        status_word[`SQDST_LEAK_CH_LSB +: 4] = leak_channel_reg;
        status_word[`SQDST_LEAK_PIN_BIT] = leak_pin_side_reg;
        status_word[`SQDST_BATT_BIT] = battery_short_flag_reg;
        status_word[`SQDST_GND_BIT] = ground_short_flag_reg;
        status_word[`SQDST_LOOP_BIT] = loop_to_loop_short_reg;
        status_word[`SQDST_CHECK_LSB +: 4] = active_check_code_reg;
        status_word[`SQDST_RES_CH_LSB +: 4] = resistance_channel_reg;
        status_word[`SQDST_UNDER_BIT] = resist_under_low_reg;
        status_word[`SQDST_OVER_BIT] = resist_over_high_reg;
        status_word[`SQDST_RSVD_BIT] = 1'b0;
        status_word[`SQDST_FET_BIT] = fet_active_flag_reg;
    end

    // field update: safety reset, then machine update, then test events
    always_comb begin
        fet_active_flag_next = fet_active_flag_reg;
        resist_over_high_next = resist_over_high_reg;
        resist_under_low_next = resist_under_low_reg;
        resistance_channel_next = resistance_channel_reg;
        active_check_code_next = active_check_code_reg;
        loop_to_loop_short_next = loop_to_loop_short_reg;
        ground_short_flag_next = ground_short_flag_reg;
        battery_short_flag_next = battery_short_flag_reg;
        leak_pin_side_next = leak_pin_side_reg;
        leak_channel_next = leak_channel_reg;
        if (safety_machine_reset) begin
            fet_active_flag_next = 1'b0;
            resist_over_high_next = 1'b0;
            resist_under_low_next = 1'b0;
            resistance_channel_next = 4'h0;
            active_check_code_next = `SQDST_CHK_NONE;
            loop_to_loop_short_next = 1'b0;
            ground_short_flag_next = 1'b0;
            battery_short_flag_next = 1'b0;
            leak_pin_side_next = 1'b0;
            leak_channel_next = 4'h0;
        end else begin
            if (fsm_update) begin
                fet_active_flag_next = fsm_fet_active;
                resist_over_high_next = fsm_over_high;
                resist_under_low_next = fsm_under_low;
                resistance_channel_next = fsm_res_channel;
                active_check_code_next = sqdst_check_clean(fsm_check_code);
                loop_to_loop_short_next = fsm_loop_short;
                ground_short_flag_next = fsm_ground_short;
                battery_short_flag_next = fsm_battery_short;
                leak_pin_side_next = fsm_leak_pin_side;
                leak_channel_next = fsm_leak_channel;
            end
            if (diag_state) begin
                fet_active_flag_next = hs_fet_on | ls_fet_on;
            end
            if (res_test_done) begin
                resist_over_high_next = (res_measured > thr_high_reg);
                resist_under_low_next = (res_measured < thr_low_reg);
            end
            if (res_channel_load) begin
                resistance_channel_next = res_channel_cfg;
            end
            if (leak_done) begin
                ground_short_flag_next = leak_ground;
                battery_short_flag_next = leak_battery;
                leak_pin_side_next = leak_pin_side;
                leak_channel_next = leak_channel;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fet_active_flag_reg <= 1'b0;
            resist_over_high_reg <= 1'b0;
            resist_under_low_reg <= 1'b0;
            resistance_channel_reg <= 4'h0;
            active_check_code_reg <= `SQDST_CHK_NONE;
            loop_to_loop_short_reg <= 1'b0;
            ground_short_flag_reg <= 1'b0;
            battery_short_flag_reg <= 1'b0;
            leak_pin_side_reg <= 1'b0;
            leak_channel_reg <= 4'h0;
        end else begin
            fet_active_flag_reg <= fet_active_flag_next;
            resist_over_high_reg <= resist_over_high_next;
            resist_under_low_reg <= resist_under_low_next;
            resistance_channel_reg <= resistance_channel_next;
            active_check_code_reg <= active_check_code_next;
            loop_to_loop_short_reg <= loop_to_loop_short_next;
            ground_short_flag_reg <= ground_short_flag_next;
            battery_short_flag_reg <= battery_short_flag_next;
            leak_pin_side_reg <= leak_pin_side_next;
            leak_channel_reg <= leak_channel_next;
        end
    end

    // write path: address and data latched independently, either order
    always_comb begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next = w_held_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && awready_reg) begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_reg) begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
        wr_addr = aw_addr_reg;
        wr_data = w_data_reg;
        wr_strb = w_strb_reg;
        if (wr_fire) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            case (wr_addr)
                `SQDST_STATUS_OFF, `SQDST_IRQ_STAT_OFF,
                `SQDST_IRQ_MASK_OFF, `SQDST_THRESH_OFF: bresp_next = `SQDST_RESP_OKAY;
                default: bresp_next = `SQDST_RESP_SLVERR;
            endcase
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        // one write in flight: no new beat until the response is taken
        awready_next = !aw_held_next && !bvalid_next;
        wready_next = !w_held_next && !bvalid_next;
    end

    // software registers and sticky interrupt bits
    always_comb begin
        ev = '0;
        ev[`SQDST_EV_RES] = res_test_done && !safety_machine_reset;
        ev[`SQDST_EV_LEAK] = leak_done && !safety_machine_reset;
        ev[`SQDST_EV_LOOP] = loop_to_loop_short_next && !loop_to_loop_short_reg;
        ev[`SQDST_EV_SHORT] = (ground_short_flag_next && !ground_short_flag_reg)
            || (battery_short_flag_next && !battery_short_flag_reg);
        thr_high_next = thr_high_reg;
        thr_low_next = thr_low_reg;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        if (wr_fire) begin
            case (wr_addr)
                `SQDST_IRQ_STAT_OFF: begin
                    if (wr_strb[0]) begin
                        irq_stat_next = irq_stat_reg & ~wr_data[3:0];
                    end
                end
                `SQDST_IRQ_MASK_OFF: begin
                    if (wr_strb[0]) begin
                        irq_mask_next = wr_data[3:0];
                    end
                end
                `SQDST_THRESH_OFF: begin
                    if (wr_strb[0]) begin
                        thr_low_next = wr_data[`SQDST_THR_LOW_LSB +: 8];
                    end
                    if (wr_strb[1]) begin
                        thr_high_next = wr_data[`SQDST_THR_HIGH_LSB +: 8];
                    end
                end
                // status word ignores writes
                default: begin
                    irq_stat_next = irq_stat_reg;
                end
            endcase
        end
        // a new event beats a clear in the same cycle
        irq_stat_next = irq_stat_next | ev;
        irq_next = |(irq_stat_next & irq_mask_next);
    end

    // read path
    always_comb begin
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid && arready_reg) begin
            arready_next = 1'b0;
            rvalid_next = 1'b1;
            rresp_next = `SQDST_RESP_OKAY;
            case (s_axi_araddr)
                `SQDST_STATUS_OFF: rdata_next = status_word;
                `SQDST_IRQ_STAT_OFF: rdata_next = {28'h0000000, irq_stat_reg};
                `SQDST_IRQ_MASK_OFF: rdata_next = {28'h0000000, irq_mask_reg};
                `SQDST_THRESH_OFF: rdata_next = {16'h0000, thr_high_reg, thr_low_reg};
                default: begin
                    rdata_next = 32'h00000000;
                    rresp_next = `SQDST_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
            arready_next = 1'b1;
        end
        // first offer after reset, when no read is pending
        if (!arready_reg && !rvalid_reg && !rvalid_next) begin
            arready_next = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `SQDST_RESP_OKAY;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= `SQDST_RESP_OKAY;
            thr_high_reg <= 8'(`SQDST_THRESH_RST >> `SQDST_THR_HIGH_LSB);
            thr_low_reg <= 8'(`SQDST_THRESH_RST >> `SQDST_THR_LOW_LSB);
            irq_stat_reg <= `SQDST_IRQ_RST;
            irq_mask_reg <= `SQDST_IRQ_RST;
            irq_reg <= 1'b0;
        end else begin
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg <= w_held_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            thr_high_reg <= thr_high_next;
            thr_low_reg <= thr_low_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg <= irq_next;
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign irq = irq_reg;

    default clocking sqdst_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    fet_follow_a: assert property (
        diag_state && !safety_machine_reset |=> fet_active_flag_reg == $past(hs_fet_on | ls_fet_on))
        else $error("fet flag does not follow driver fets");
    over_high_a: assert property (
        res_test_done && !safety_machine_reset
        |=> resist_over_high_reg == ($past(res_measured) > $past(thr_high_reg)))
        else $error("over-high flag wrong after resistance test");
    under_low_a: assert property (
        res_test_done && !safety_machine_reset
        |=> resist_under_low_reg == ($past(res_measured) < $past(thr_low_reg)))
        else $error("under-low flag wrong after resistance test");
    res_channel_a: assert property (
        res_channel_load && !safety_machine_reset |=> resistance_channel_reg == $past(res_channel_cfg))
        else $error("resistance channel not loaded");
    check_code_a: assert property (
        active_check_code_reg < 4'h8 && active_check_code_reg != 4'h4)
        else $error("unused check code reported");
    leak_result_a: assert property (
        leak_done && !safety_machine_reset && !fsm_update
        |=> {ground_short_flag_reg, battery_short_flag_reg, leak_pin_side_reg, leak_channel_reg}
            == $past({leak_ground, leak_battery, leak_pin_side, leak_channel}))
        else $error("leakage result not captured");
    loop_short_a: assert property (
        fsm_update && !safety_machine_reset |=> loop_to_loop_short_reg == $past(fsm_loop_short))
        else $error("loop short flag not updated");
    safety_clear_a: assert property (
        safety_machine_reset |=> status_word == 32'h00000000)
        else $error("safety reset left a field set");
    fields_stable_a: assert property (
        !safety_machine_reset && !fsm_update && !diag_state && !res_test_done
        && !res_channel_load && !leak_done |=> $stable(status_word))
        else $error("status changed without cause");
    read_only_a: assert property (
        wr_fire && wr_addr == `SQDST_STATUS_OFF && !safety_machine_reset && !fsm_update
        && !diag_state && !res_test_done && !res_channel_load && !leak_done
        |=> $stable(status_word) && !status_word[`SQDST_RSVD_BIT])
        else $error("status word altered by write");
    irq_level_a: assert property (
        irq == |(irq_stat_reg & irq_mask_reg))
        else $error("interrupt does not match unmasked status bits");

    leak_seen_c: cover property (leak_done ##1 irq_stat_reg[`SQDST_EV_LEAK]);
    range_seen_c: cover property (res_test_done ##1 resist_over_high_reg);
    write_resp_c: cover property (s_axi_bvalid && s_axi_bready);
    read_resp_c: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == `SQDST_RESP_OKAY);

endmodule : sqdst_status

// >>> test/sqdst_host.sv
// host model: axi4-lite master doing one read or one write at a time
`timescale 1ns/1ps
module sqdst_host (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr = 8'h00,
    output logic s_axi_awvalid = 1'b0,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata = 32'h0,
    output logic s_axi_wvalid = 1'b0,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready = 1'b0,
    output logic [7:0] s_axi_araddr = 8'h00,
    output logic s_axi_arvalid = 1'b0,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready = 1'b0
);
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // address and data may be taken on different edges; the response
        // only follows both, so one loop watches all three handshakes
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
endmodule : sqdst_host

// >>> test/sqdst_status_bench.sv
// self-checking bench for the squib loop status bank
`timescale 1ns/1ps
module sqdst_status_bench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr, res_measured;
    logic [31:0] s_axi_wdata, s_axi_rdata, exp_st, d;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic safety_machine_reset, diag_state, hs_fet_on, ls_fet_on, fsm_update, res_test_done;
    logic res_channel_load, leak_done, leak_ground, leak_battery, leak_pin_side;
    logic fsm_fet_active, fsm_over_high, fsm_under_low, fsm_loop_short, fsm_ground_short;
    logic fsm_battery_short, fsm_leak_pin_side;
    logic [3:0] fsm_res_channel, fsm_check_code, fsm_leak_channel, res_channel_cfg, leak_channel;
    int miscompares, compares, cycles;

    sqdst_status u_sqdst_status (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hf));
    sqdst_host u_sqdst_host (.*);

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    // whole run needs well under a thousand cycles; a hang stops here
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) tally_and_finish(1);
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) $display("Error at %0t: got %h expected %h", $time, seen, exp);
        if (seen !== exp) miscompares++;
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        u_sqdst_host.rd(a, d, r);
        chk(d, e);
    endtask : rc
    task automatic tally_and_finish(input int extra);
        miscompares += extra;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task automatic t_reset();
        rc(8'h00, 32'h0);
        rc(8'h0c, 32'h0000ff00);
        rc(8'h10, 32'h0);
        chk({30'h0, r}, 32'h2);
    endtask : t_reset
    // thresholds low 0x20 high 0x80; 0x80 sits on the edge and sets neither flag
    task automatic t_events();
        logic [7:0] m[5] = '{8'h90, 8'h10, 8'h40, 8'h80, 8'h30};
        logic [6:0] v[5] = '{7'h52, 7'h27, 7'h0f, 7'h74, 7'h03};
        u_sqdst_host.wr(8'h0c, 32'h00008020, r);
        diag_state <= 1'b1;
        foreach (m[i]) begin
            {hs_fet_on, ls_fet_on} <= v[i][5:4];
            {res_measured, res_channel_cfg} <= {m[i], m[i][7:4]};
            {leak_ground, leak_battery, leak_pin_side, leak_channel} <= v[i];
            {res_test_done, res_channel_load, leak_done} <= 3'b111;
            @(posedge aclk);
            {res_test_done, res_channel_load, leak_done} <= 3'b000;
            exp_st = {12'h0, |v[i][5:4], 1'b0, m[i] > 8'h80, m[i] < 8'h20, m[i][7:4], 5'h0, v[i]};
            rc(8'h00, exp_st);
            chk({25'h0, d[6:0]}, {25'h0, v[i]});
        end
        diag_state <= 1'b0;
    endtask : t_events
    task automatic t_fsm();
        logic [3:0] c;
        logic [3:0] k;
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            {fsm_fet_active, fsm_over_high, fsm_under_low, fsm_loop_short} <= c;
            {fsm_ground_short, fsm_battery_short, fsm_leak_pin_side} <= c[2:0];
            {fsm_res_channel, fsm_check_code, fsm_leak_channel} <= {~c, c, c};
            fsm_update <= 1'b1;
            @(posedge aclk);
            fsm_update <= 1'b0;
            k = (c inside {4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7}) ? c : 4'h0;
            exp_st = {12'h0, c[3], 1'b0, c[2], c[1], ~c, k, c[0], c[2:0], c};
            rc(8'h00, exp_st);
        end
    endtask : t_fsm
    task automatic t_irq();
        rc(8'h04, 32'hf);
        chk({31'h0, irq}, 32'h0);
        u_sqdst_host.wr(8'h08, 32'h1, r);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        u_sqdst_host.wr(8'h04, 32'h1, r);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        rc(8'h04, 32'he);
    endtask : t_irq
    task automatic t_ro();
        u_sqdst_host.wr(8'h00, 32'hffffffff, r);
        chk({30'h0, r}, 32'h0);
        u_sqdst_host.wr(8'h10, 32'h0, r);
        chk({30'h0, r}, 32'h2);
        rc(8'h00, exp_st);
        safety_machine_reset <= 1'b1;
        @(posedge aclk);
        safety_machine_reset <= 1'b0;
        rc(8'h00, 32'h0);
    endtask : t_ro

    initial begin
        aresetn = 1'b0;
        {safety_machine_reset, diag_state, hs_fet_on, ls_fet_on, fsm_update, res_test_done} = '0;
        {res_channel_load, leak_done, leak_ground, leak_battery, leak_pin_side, leak_channel} = '0;
        {fsm_fet_active, fsm_over_high, fsm_under_low, fsm_loop_short, fsm_ground_short} = '0;
        {fsm_battery_short, fsm_leak_pin_side, fsm_res_channel, fsm_check_code} = '0;
        {fsm_leak_channel, res_measured, res_channel_cfg} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_events();
        t_fsm();
        t_irq();
        t_ro();
        tally_and_finish(0);
    end
endmodule : sqdst_status_bench
